// ### inc/lac_pkg.sv
package lac_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 16;
  localparam int CUR_W   = 8;
  localparam int LOSS_W  = 11;
  localparam int PWR_W   = 12;
  localparam int VM_W    = 8;
  localparam int CNT_W   = 8;
  localparam int HC_W    = 6;
  localparam int CTRL_W  = 11;

  // ----------------------------------------------------------------
  // Register map (word addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_LOSS_LOW = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_LOSS_HI  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_LIMITS   = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_BAND     = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_FSCALE   = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_COUNT    = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_LOSS_EST = 4'hA;
  localparam logic [ADDR_W-1:0] ADDR_LEARN_VM = 4'hB;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [CUR_W-1:0]  FSCALE_RST  = 8'hFF;
  localparam logic [CUR_W-1:0]  CEIL_RST    = 8'hFF;
  localparam logic [CUR_W-1:0]  FLOOR_RST   = 8'h20;
  localparam logic [CNT_W-1:0]  UPPER_RST   = 8'h20;
  localparam logic [CNT_W-1:0]  LOWER_RST   = 8'h08;
  localparam logic [VM_W-1:0]   LEARN_VM_RST = 8'h01;
  localparam logic [LOSS_W-1:0] LOSS_MAX    = 11'h7FF;
  localparam logic [CNT_W-1:0]  CNT_MAX     = 8'hFF;
  localparam logic [CUR_W-1:0]  CUR_MAX     = 8'hFF;
  localparam logic [CUR_W-1:0]  COUNT_GAIN  = 8'h40;
  localparam int                BASE_SHIFT  = 3;

  localparam logic [CUR_W-1:0] INC_VAL0 = 8'h80;
  localparam logic [CUR_W-1:0] INC_VAL1 = 8'h10;
  localparam logic [CUR_W-1:0] INC_VAL2 = 8'h20;
  localparam logic [CUR_W-1:0] INC_VAL3 = 8'h40;
  localparam logic [2:0]       INC_SHF0 = 3'h7;
  localparam logic [2:0]       INC_SHF1 = 3'h4;
  localparam logic [2:0]       INC_SHF2 = 3'h5;
  localparam logic [2:0]       INC_SHF3 = 3'h6;

  localparam logic [HC_W-1:0] DWELL_N0 = 6'h08;
  localparam logic [HC_W-1:0] DWELL_N1 = 6'h10;
  localparam logic [HC_W-1:0] DWELL_N2 = 6'h18;
  localparam logic [HC_W-1:0] DWELL_N3 = 6'h20;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] base;
    logic [1:0] dwell;
    logic [1:0] inc;
    logic       go;
    logic       en;
  } lac_ctrl_t;

  typedef struct packed {
    logic raised;
    logic learned;
  } lac_irq_t;

  typedef enum logic [1:0] {
    LAC_IDLE,
    LAC_LOW,
    LAC_HIGH
  } lac_learn_state_t;

endpackage

// ### src/lac_top.sv
`timescale 1ns/1ns
module lac_top (
  input  wire logic                         CORE_CLK,
  input  wire logic                         SRST,
  input  wire logic [lac_pkg::ADDR_W-1:0]   REG_ADDR,
  input  wire logic [lac_pkg::DATA_W-1:0]   REG_WDATA,
  input  wire logic                         REG_WR,
  input  wire logic                         REG_RD,
  output logic      [lac_pkg::DATA_W-1:0]   REG_RDATA,
  input  wire logic                         HALF_CYCLE,
  input  wire logic [lac_pkg::PWR_W-1:0]    SUPPLY_POWER,
  input  wire logic [lac_pkg::VM_W-1:0]     SUPPLY_VOLTAGE,
  output logic      [lac_pkg::CUR_W-1:0]    COIL_CURRENT,
  output logic                              LEARN_ACTIVE,
  output logic                              IRQ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lac_pkg::lac_ctrl_t         ctrl_reg;
  lac_pkg::lac_ctrl_t         ctrl_next;
  lac_pkg::lac_learn_state_t  state_reg;
  lac_pkg::lac_irq_t          status_reg;
  lac_pkg::lac_irq_t          status_next;
  lac_pkg::lac_irq_t          mask_reg;
  logic [lac_pkg::HC_W-1:0]   hc_cnt_reg;
  logic [16:0]                acc_reg;
  logic [16:0]                acc_sum;
  logic [16:0]                avg;
  logic [lac_pkg::LOSS_W-1:0] avg_sat;
  logic [lac_pkg::LOSS_W-1:0] sample_low_reg;
  logic [lac_pkg::LOSS_W-1:0] learned_loss_low_reg;
  logic [lac_pkg::LOSS_W-1:0] learned_loss_high_reg;
  logic [lac_pkg::VM_W-1:0]   learn_vm_reg;
  logic [lac_pkg::CUR_W-1:0]  cur_reg;
  logic [lac_pkg::CUR_W-1:0]  ceil_reg;
  logic [lac_pkg::CUR_W-1:0]  floor_reg;
  logic [lac_pkg::CNT_W-1:0]  upper_reg;
  logic [lac_pkg::CNT_W-1:0]  lower_reg;
  logic [lac_pkg::CUR_W-1:0]  fscale_reg;
  logic [lac_pkg::CNT_W-1:0]  load_power_count_reg;
  logic [lac_pkg::LOSS_W-1:0] constant_loss_estimate_reg;
  logic                       learn_complete_flag_reg;
  logic                       learn_active_reg;
  logic                       irq_reg;
  logic [lac_pkg::DATA_W-1:0] rdata_reg;
  logic [lac_pkg::HC_W-1:0]   dwell_n;
  logic [lac_pkg::CUR_W-1:0]  inc_val;
  logic [2:0]                 inc_shift;
  logic [lac_pkg::CUR_W-1:0]  level_low;
  logic [8:0]                 level_sum;
  logic [lac_pkg::CUR_W-1:0]  level_high;
  logic                       dwell_last;
  logic                       learn_finish;
  logic                       learning;
  logic signed [12:0]         span;
  logic signed [9:0]          di;
  logic signed [22:0]         prod;
  logic signed [22:0]         interp;
  logic [lac_pkg::LOSS_W-1:0] loss_i;
  logic [18:0]                loss_v;
  logic [lac_pkg::LOSS_W-1:0] loss_now;
  logic signed [12:0]         pdiff;
  logic [19:0]                num;
  logic [19:0]                quot;
  logic [lac_pkg::CNT_W-1:0]  count_now;
  logic                       raise_evt;
  logic                       wr_ctrl;

  assign wr_ctrl  = REG_WR && (REG_ADDR == lac_pkg::ADDR_CTRL);
  assign learning = (state_reg != lac_pkg::LAC_IDLE);

  // ----------------------------------------------------------------
  // Learning level and dwell decode
  // ----------------------------------------------------------------
  always_comb begin
    case (ctrl_reg.inc)
      2'h0: begin
        inc_val   = lac_pkg::INC_VAL0;
        inc_shift = lac_pkg::INC_SHF0;
      end
      2'h1: begin
        inc_val   = lac_pkg::INC_VAL1;
        inc_shift = lac_pkg::INC_SHF1;
      end
      2'h2: begin
        inc_val   = lac_pkg::INC_VAL2;
        inc_shift = lac_pkg::INC_SHF2;
      end
      default: begin
        inc_val   = lac_pkg::INC_VAL3;
        inc_shift = lac_pkg::INC_SHF3;
      end
    endcase
    case (ctrl_reg.dwell)
      2'h0:    dwell_n = lac_pkg::DWELL_N0;
      2'h1:    dwell_n = lac_pkg::DWELL_N1;
      2'h2:    dwell_n = lac_pkg::DWELL_N2;
      default: dwell_n = lac_pkg::DWELL_N3;
    endcase
  end

  assign level_low  = {ctrl_reg.base, 3'h0};
  assign level_sum  = {1'b0, level_low} + {1'b0, inc_val};
  // Final level clips at full range rather than wrapping
  assign level_high = level_sum[8] ? lac_pkg::CUR_MAX : level_sum[7:0];

  // ----------------------------------------------------------------
  // Per-level averaging of supply power
  // ----------------------------------------------------------------
  assign acc_sum    = acc_reg + {5'h00, SUPPLY_POWER};
  assign avg        = acc_sum / {11'h000, dwell_n};
  assign avg_sat    = (avg > {6'h00, lac_pkg::LOSS_MAX}) ?
                      lac_pkg::LOSS_MAX : avg[lac_pkg::LOSS_W-1:0];
  assign dwell_last = HALF_CYCLE && (hc_cnt_reg == dwell_n - 6'h01);
  assign learn_finish = (state_reg == lac_pkg::LAC_HIGH) && dwell_last
                        && ctrl_reg.en;

  // ----------------------------------------------------------------
  // Loss estimate: interpolate, then scale by voltage
  // ----------------------------------------------------------------
  always_comb begin
    span   = $signed({2'h0, learned_loss_high_reg})
           - $signed({2'h0, learned_loss_low_reg});
    di     = $signed({2'h0, cur_reg}) - $signed({2'h0, level_low});
    prod   = span * di;
    interp = $signed({12'h000, learned_loss_low_reg})
           + (prod >>> inc_shift);
    if (interp < 0)
      loss_i = '0;
    else if (interp > $signed({12'h000, lac_pkg::LOSS_MAX}))
      loss_i = lac_pkg::LOSS_MAX;
    else
      loss_i = interp[lac_pkg::LOSS_W-1:0];
    // Zero supply reading would divide by zero; keep unscaled
    if (SUPPLY_VOLTAGE == '0)
      loss_v = {8'h00, loss_i};
    else
      loss_v = ({8'h00, loss_i} * {11'h000, learn_vm_reg})
             / {11'h000, SUPPLY_VOLTAGE};
    loss_now = (loss_v > {8'h00, lac_pkg::LOSS_MAX}) ?
               lac_pkg::LOSS_MAX : loss_v[lac_pkg::LOSS_W-1:0];
  end

  // ----------------------------------------------------------------
  // Load power count
  // ----------------------------------------------------------------
  always_comb begin
    pdiff = $signed({1'b0, SUPPLY_POWER})
          - $signed({2'h0, loss_now});
    num   = (pdiff < 0) ? '0 :
            {8'h00, pdiff[11:0]} * {12'h000, lac_pkg::COUNT_GAIN};
    quot  = (fscale_reg == '0) ? num :
            num / {12'h000, fscale_reg};
    count_now = (quot > {12'h000, lac_pkg::CNT_MAX}) ?
                lac_pkg::CNT_MAX : quot[lac_pkg::CNT_W-1:0];
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next    = lac_pkg::lac_ctrl_t'(REG_WDATA[lac_pkg::CTRL_W-1:0]);
      ctrl_next.go = ctrl_reg.go | ctrl_next.go;
    end
    if (learn_finish)
      ctrl_next.go = 1'b0;
    // Learning needs the adaptive mode; dropping enable aborts it
    if (!ctrl_next.en)
      ctrl_next.go = 1'b0;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST)
      ctrl_reg <= '0;
    else
      ctrl_reg <= ctrl_next;
  end

  // ----------------------------------------------------------------
  // Learning sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_reg        <= lac_pkg::LAC_IDLE;
      hc_cnt_reg       <= '0;
      acc_reg          <= '0;
      sample_low_reg   <= '0;
      learn_active_reg <= 1'b0;
    end else if (!ctrl_reg.en) begin
      state_reg        <= lac_pkg::LAC_IDLE;
      learn_active_reg <= 1'b0;
    end else begin
      case (state_reg)
        lac_pkg::LAC_IDLE: begin
          hc_cnt_reg <= '0;
          acc_reg    <= '0;
          if (ctrl_reg.go) begin
            state_reg        <= lac_pkg::LAC_LOW;
            learn_active_reg <= 1'b1;
          end
        end
        lac_pkg::LAC_LOW: begin
          if (dwell_last) begin
            sample_low_reg <= avg_sat;
            hc_cnt_reg     <= '0;
            acc_reg        <= '0;
            state_reg      <= lac_pkg::LAC_HIGH;
          end else if (HALF_CYCLE) begin
            hc_cnt_reg <= hc_cnt_reg + 6'h01;
            acc_reg    <= acc_sum;
          end
        end
        lac_pkg::LAC_HIGH: begin
          if (dwell_last) begin
            state_reg        <= lac_pkg::LAC_IDLE;
            learn_active_reg <= 1'b0;
          end else if (HALF_CYCLE) begin
            hc_cnt_reg <= hc_cnt_reg + 6'h01;
            acc_reg    <= acc_sum;
          end
        end
        default: state_reg <= lac_pkg::LAC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Learned results and reference voltage
  // ----------------------------------------------------------------
  // Completion beats a software write in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      learned_loss_low_reg  <= '0;
      learned_loss_high_reg <= '0;
      learn_vm_reg          <= lac_pkg::LEARN_VM_RST;
    end else if (learn_finish) begin
      learned_loss_low_reg  <= sample_low_reg;
      learned_loss_high_reg <= avg_sat;
      learn_vm_reg          <= SUPPLY_VOLTAGE;
    end else if (REG_WR) begin
      if (REG_ADDR == lac_pkg::ADDR_LOSS_LOW)
        learned_loss_low_reg <= REG_WDATA[lac_pkg::LOSS_W-1:0];
      else if (REG_ADDR == lac_pkg::ADDR_LOSS_HI)
        learned_loss_high_reg <= REG_WDATA[lac_pkg::LOSS_W-1:0];
      else if (REG_ADDR == lac_pkg::ADDR_LEARN_VM)
        learn_vm_reg <= REG_WDATA[lac_pkg::VM_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      floor_reg  <= lac_pkg::FLOOR_RST;
      ceil_reg   <= lac_pkg::CEIL_RST;
      lower_reg  <= lac_pkg::LOWER_RST;
      upper_reg  <= lac_pkg::UPPER_RST;
      fscale_reg <= lac_pkg::FSCALE_RST;
      mask_reg   <= '0;
    end else if (REG_WR) begin
      if (REG_ADDR == lac_pkg::ADDR_LIMITS) begin
        floor_reg <= REG_WDATA[7:0];
        ceil_reg  <= REG_WDATA[15:8];
      end else if (REG_ADDR == lac_pkg::ADDR_BAND) begin
        lower_reg <= REG_WDATA[7:0];
        upper_reg <= REG_WDATA[15:8];
      end else if (REG_ADDR == lac_pkg::ADDR_FSCALE) begin
        fscale_reg <= REG_WDATA[lac_pkg::CUR_W-1:0];
      end else if (REG_ADDR == lac_pkg::ADDR_INT_MASK) begin
        mask_reg <= lac_pkg::lac_irq_t'(REG_WDATA[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Coil current regulation
  // ----------------------------------------------------------------
  assign raise_evt = ctrl_reg.en && !learning && HALF_CYCLE
                     && (count_now > upper_reg);

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      cur_reg <= lac_pkg::FSCALE_RST;
    end else if (learn_finish) begin
      cur_reg <= ceil_reg;
    end else if (state_reg == lac_pkg::LAC_LOW) begin
      cur_reg <= level_low;
    end else if (state_reg == lac_pkg::LAC_HIGH) begin
      cur_reg <= level_high;
    end else if (!ctrl_reg.en) begin
      cur_reg <= fscale_reg;
    end else if (raise_evt) begin
      // Jump straight to ceiling: one slow step could lose steps
      cur_reg <= ceil_reg;
    end else if (cur_reg > ceil_reg) begin
      cur_reg <= ceil_reg;
    end else if (cur_reg < floor_reg) begin
      cur_reg <= floor_reg;
    end else if (HALF_CYCLE && (count_now < lower_reg)
                 && (cur_reg > floor_reg)) begin
      cur_reg <= cur_reg - 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      load_power_count_reg       <= '0;
      constant_loss_estimate_reg <= '0;
    end else if (HALF_CYCLE) begin
      load_power_count_reg       <= count_now;
      constant_loss_estimate_reg <= loss_now;
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SRST)
      learn_complete_flag_reg <= 1'b0;
    else if (learn_finish)
      learn_complete_flag_reg <= 1'b1;
    else if (state_reg == lac_pkg::LAC_IDLE && ctrl_reg.go)
      learn_complete_flag_reg <= 1'b0;
  end

  // New events win over a write-one-to-clear in the same cycle
  always_comb begin
    status_next = status_reg;
    if (REG_WR && (REG_ADDR == lac_pkg::ADDR_INT_STAT))
      status_next = status_reg & ~lac_pkg::lac_irq_t'(REG_WDATA[1:0]);
    status_next.learned = status_next.learned | learn_finish;
    status_next.raised  = status_next.raised | raise_evt;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      status_reg <= '0;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg    <= |(status_next & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rdata_reg <= '0;
    end else if (!REG_RD) begin
      rdata_reg <= '0;
    end else if (REG_ADDR == lac_pkg::ADDR_CTRL) begin
      rdata_reg <= {5'h00, ctrl_reg};
    end else if (REG_ADDR == lac_pkg::ADDR_STATUS) begin
      rdata_reg <= {cur_reg, 6'h00, learning, learn_complete_flag_reg};
    end else if (REG_ADDR == lac_pkg::ADDR_INT_STAT) begin
      rdata_reg <= {14'h0000, status_reg};
    end else if (REG_ADDR == lac_pkg::ADDR_INT_MASK) begin
      rdata_reg <= {14'h0000, mask_reg};
    end else if (REG_ADDR == lac_pkg::ADDR_LOSS_LOW) begin
      rdata_reg <= {5'h00, learned_loss_low_reg};
    end else if (REG_ADDR == lac_pkg::ADDR_LOSS_HI) begin
      rdata_reg <= {5'h00, learned_loss_high_reg};
    end else if (REG_ADDR == lac_pkg::ADDR_LIMITS) begin
      rdata_reg <= {ceil_reg, floor_reg};
    end else if (REG_ADDR == lac_pkg::ADDR_BAND) begin
      rdata_reg <= {upper_reg, lower_reg};
    end else if (REG_ADDR == lac_pkg::ADDR_FSCALE) begin
      rdata_reg <= {8'h00, fscale_reg};
    end else if (REG_ADDR == lac_pkg::ADDR_COUNT) begin
      rdata_reg <= {8'h00, load_power_count_reg};
    end else if (REG_ADDR == lac_pkg::ADDR_LOSS_EST) begin
      rdata_reg <= {5'h00, constant_loss_estimate_reg};
    end else if (REG_ADDR == lac_pkg::ADDR_LEARN_VM) begin
      rdata_reg <= {8'h00, learn_vm_reg};
    end else begin
      rdata_reg <= '0;
    end
  end

  assign REG_RDATA    = rdata_reg;
  assign COIL_CURRENT = cur_reg;
  assign LEARN_ACTIVE = learn_active_reg;
  assign IRQ          = irq_reg;

endmodule

// ### testbench/lac_chk.sv
`timescale 1ns/1ns
module lac_chk (
  input wire logic                       CORE_CLK,
  input wire logic                       SRST,
  input wire logic [lac_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [lac_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic                       REG_WR,
  input wire logic                       REG_RD,
  input wire logic [lac_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic                       HALF_CYCLE,
  input wire logic [lac_pkg::CUR_W-1:0]  COIL_CURRENT,
  input wire logic                       LEARN_ACTIVE,
  input wire logic                       IRQ
);
  logic [4:0] base_reg;
  logic       en_reg;
  logic       msk_reg;
  logic [7:0] ceil_reg;
  logic [7:0] fs_reg;

  // Shadow only the fields the properties need
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      base_reg <= 5'h00;
      en_reg   <= 1'b0;
      msk_reg  <= 1'b0;
      ceil_reg <= lac_pkg::CEIL_RST;
      fs_reg   <= lac_pkg::FSCALE_RST;
    end else if (REG_WR) begin
      case (REG_ADDR)
        lac_pkg::ADDR_CTRL: begin
          base_reg <= REG_WDATA[10:6];
          en_reg   <= REG_WDATA[0];
        end
        lac_pkg::ADDR_INT_MASK: msk_reg <= REG_WDATA[0];
        lac_pkg::ADDR_LIMITS: ceil_reg <= REG_WDATA[15:8];
        lac_pkg::ADDR_FSCALE: fs_reg <= REG_WDATA[7:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  a_learn_start: assert property (
    REG_WR && REG_ADDR == lac_pkg::ADDR_CTRL && REG_WDATA[1:0] == 2'b11
    && !LEARN_ACTIVE |-> ##[1:2] LEARN_ACTIVE)
    else $error("Learning did not start");
  a_learn_level: assert property (
    $rose(LEARN_ACTIVE) |-> ##[0:2] COIL_CURRENT == {base_reg, 3'b000})
    else $error("Wrong first learning level");
  a_learn_ceiling: assert property (
    $fell(LEARN_ACTIVE) |-> ##[0:1] COIL_CURRENT == ceil_reg)
    else $error("Current not at ceiling after learning");
  a_irq_learn: assert property (
    $fell(LEARN_ACTIVE) && msk_reg |-> ##[1:2] IRQ)
    else $error("No interrupt after learning");
  a_off_fullscale: assert property (
    !en_reg && !LEARN_ACTIVE ##1 !en_reg && $stable(fs_reg)
    |=> COIL_CURRENT == fs_reg)
    else $error("Current adjusted while disabled");
  a_down_step: assert property (
    en_reg && !LEARN_ACTIVE && !$past(LEARN_ACTIVE)
    && COIL_CURRENT < $past(COIL_CURRENT)
    |-> $past(HALF_CYCLE) && COIL_CURRENT == $past(COIL_CURRENT) - 8'h01)
    else $error("Bad current reduction");
  a_raise_ceiling: assert property (
    en_reg && !LEARN_ACTIVE && !$past(LEARN_ACTIVE)
    && COIL_CURRENT > $past(COIL_CURRENT)
    |-> $past(HALF_CYCLE) && COIL_CURRENT == ceil_reg)
    else $error("Bad current raise");
  a_learn_hold: assert property (
    LEARN_ACTIVE && $past(LEARN_ACTIVE) && $past(LEARN_ACTIVE, 2)
    && COIL_CURRENT != $past(COIL_CURRENT)
    |-> $past(HALF_CYCLE) || $past(HALF_CYCLE, 2))
    else $error("Learning level moved between half-cycles");

  c_learn_done: cover property ($fell(LEARN_ACTIVE));
  c_irq_drop: cover property (IRQ ##1 !IRQ);
  c_floor: cover property (en_reg && COIL_CURRENT == lac_pkg::FLOOR_RST);
endmodule

// ### testbench/lac_motor.sv
`timescale 1ns/1ns
module lac_motor (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic [lac_pkg::CUR_W-1:0] coil_current,
  input  wire logic [lac_pkg::PWR_W-1:0] load_power,
  output logic                           half_cycle,
  output logic      [lac_pkg::PWR_W-1:0] supply_power
);
  logic [4:0] phase_reg;

  // Losses linear in current, load adds on top
  assign supply_power = {2'h0, coil_current, 2'h0} + load_power;
  assign half_cycle = (phase_reg == 5'h13);

  // Fixed speed: one half-cycle every 20 clocks
  always_ff @(posedge clk) begin
    if (srst || half_cycle) begin
      phase_reg <= 5'h00;
    end else begin
      phase_reg <= phase_reg + 5'h01;
    end
  end
endmodule

// ### testbench/lac_bench.sv
`timescale 1ns/1ns
module lac_bench;
  logic                       clk;
  logic                       srst;
  logic [lac_pkg::ADDR_W-1:0] addr;
  logic [lac_pkg::DATA_W-1:0] wdata;
  logic                       wr;
  logic                       rd;
  logic [lac_pkg::DATA_W-1:0] rdata;
  logic                       hc;
  logic [lac_pkg::PWR_W-1:0]  pwr;
  logic [lac_pkg::PWR_W-1:0]  load;
  logic [lac_pkg::VM_W-1:0]   vm;
  logic [lac_pkg::CUR_W-1:0]  cur;
  logic                       lact;
  logic                       irq;
  logic [15:0]                e;
  logic [15:0]                inc_tab [4];
  int                         miscompares;
  int                         tests_run;
  int                         pulses;
  int                         p0;

  lac_top i_dut (
    .CORE_CLK       (clk),
    .SRST           (srst),
    .REG_ADDR       (addr),
    .REG_WDATA      (wdata),
    .REG_WR         (wr),
    .REG_RD         (rd),
    .REG_RDATA      (rdata),
    .HALF_CYCLE     (hc),
    .SUPPLY_POWER   (pwr),
    .SUPPLY_VOLTAGE (vm),
    .COIL_CURRENT   (cur),
    .LEARN_ACTIVE   (lact),
    .IRQ            (irq)
  );
  lac_motor i_motor (
    .clk          (clk),
    .srst         (srst),
    .coil_current (cur),
    .load_power   (load),
    .half_cycle   (hc),
    .supply_power (pwr)
  );

  always #5 clk = ~clk;
  always @(posedge clk) if (hc === 1'b1 && lact === 1'b1) pulses++;

  task automatic final_report();
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp,
                        input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  // Sel 0 pulse, 1 learning over, 2 current equals v, 3 learning on
  task automatic wait_for(input int sel, input logic [7:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (n < 6000 && !((sel == 0 && hc === 1'b1) ||
               (sel == 1 && lact === 1'b0) || (sel == 2 && cur === v) ||
               (sel == 3 && lact === 1'b1)));
    if (n >= 6000) begin
      miscompares++;
      final_report();
    end
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    load = 12'h000;
    vm = 8'h18;
    miscompares = 0;
    tests_run = 0;
    pulses = 0;
    inc_tab = '{16'h0080, 16'h0010, 16'h0020, 16'h0040};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk("coil", 16'h00FF, {8'h00, cur});
    rd_reg(lac_pkg::ADDR_LIMITS, 16'hFF20, "limits");
    rd_reg(lac_pkg::ADDR_BAND, 16'h2008, "band");
    wr_reg(4'hC, 16'hFFFF);
    rd_reg(4'hC, 16'h0000, "unmapped");
    wr_reg(lac_pkg::ADDR_INT_MASK, 16'h0003);
    // Unloaded motor, base code 3, every increment and dwell code
    for (int i = 0; i < 4; i++) begin
      wait_for(0, 8'h00);
      p0 = pulses;
      wr_reg(lac_pkg::ADDR_CTRL, 16'h00C3 | 16'(i * 20));
      wait_for(3, 8'h00);
      wait_for(1, 8'h00);
      chk("pulses", 16'(16 * (i + 1)), 16'(pulses - p0));
      rd_reg(lac_pkg::ADDR_STATUS, 16'hFF01, "status");
      rd_reg(lac_pkg::ADDR_CTRL, 16'h00C1 | 16'(i * 20), "ctrl");
      rd_reg(lac_pkg::ADDR_LOSS_LOW, 16'h0060, "low");
      e = (inc_tab[i] + 16'h0018) << 2;
      rd_reg(lac_pkg::ADDR_LOSS_HI, e, "high");
    end
    rd_reg(lac_pkg::ADDR_LEARN_VM, 16'h0018, "ref volt");
    chk("irq", 16'h0001, {15'h0000, irq});
    wr_reg(lac_pkg::ADDR_INT_MASK, 16'h0000);
    @(posedge clk);
    #1;
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr_reg(lac_pkg::ADDR_INT_MASK, 16'h0003);
    wr_reg(lac_pkg::ADDR_INT_STAT, 16'h0001);
    @(posedge clk);
    #1;
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    wr_reg(lac_pkg::ADDR_LOSS_HI, 16'h07FF);
    rd_reg(lac_pkg::ADDR_LOSS_HI, 16'h07FF, "preload");
    wr_reg(lac_pkg::ADDR_LOSS_HI, 16'h0160);
    wait_for(2, 8'h20);
    chk("floor", 16'h0020, {8'h00, cur});
    wait_for(0, 8'h00);
    rd_reg(lac_pkg::ADDR_LOSS_EST, 16'h0080, "loss");
    rd_reg(lac_pkg::ADDR_COUNT, 16'h0000, "idle count");
    // Doubled supply halves the loss share at the same current
    @(posedge clk);
    vm <= 8'h30;
    wait_for(0, 8'h00);
    rd_reg(lac_pkg::ADDR_LOSS_EST, 16'h0040, "scaled loss");
    rd_reg(lac_pkg::ADDR_COUNT, 16'h0010, "scaled count");
    @(posedge clk);
    vm <= 8'h18;
    load <= 12'h200;
    wait_for(2, 8'hFF);
    chk("raise", 16'h00FF, {8'h00, cur});
    rd_reg(lac_pkg::ADDR_COUNT, 16'h0080, "count");
    rd_reg(lac_pkg::ADDR_INT_STAT, 16'h0002, "raised");
    wr_reg(lac_pkg::ADDR_FSCALE, 16'h0080);
    wr_reg(lac_pkg::ADDR_CTRL, 16'h0000);
    wait_for(2, 8'h80);
    chk("off", 16'h0080, {8'h00, cur});
    final_report();
  end
endmodule

bind lac_top lac_chk u_chk (
  .CORE_CLK     (CORE_CLK),
  .SRST         (SRST),
  .REG_ADDR     (REG_ADDR),
  .REG_WDATA    (REG_WDATA),
  .REG_WR       (REG_WR),
  .REG_RD       (REG_RD),
  .REG_RDATA    (REG_RDATA),
  .HALF_CYCLE   (HALF_CYCLE),
  .COIL_CURRENT (COIL_CURRENT),
  .LEARN_ACTIVE (LEARN_ACTIVE),
  .IRQ          (IRQ)
);
